// ==== common/acm_cfg.svh ====
// constants for the converter mode, clock and result control block
`ifndef ACM_CFG_SVH
`define ACM_CFG_SVH
`define ACM_REG_CONTROL     4'h1
`define ACM_REG_RESULT      4'h2
`define ACM_MODE_LSB        2
`define ACM_MODE_MSB        5
`define ACM_CLKSEL_LSB      0
`define ACM_CLKSEL_MSB      1
`define ACM_DUTY_BIT        6
`define ACM_CONTROL_RESET   16'h0000
`define ACM_RESULT_RESET    16'h0000
`define ACM_OSC_HALF        10'd651
`define ACM_CAL_CYCLES      16'h0040
`define ACM_SEQ_CYCLES      16'h0020
`define ACM_DUTY_ON_QUARTER 16'h0020
`define ACM_DUTY_OFF_LONG   16'h01e0
`define ACM_DUTY_OFF_SHORT  16'h0060
`define ACM_APB_CONTROL     12'h004
`define ACM_APB_STATUS      12'h008
`define ACM_APB_RESULT      12'h00c
`define ACM_APB_WRITE       12'h000
`endif

// ==== common/acm_link_if.sv ====
// register link between host end and converter end
`timescale 1ns/1ps
`default_nettype none
interface acm_link_if;
   logic        regWrite;
   logic        regRead;
   logic [3:0]  regAddr;
   logic [15:0] regWdata;
   logic [15:0] regRdata;
   logic        syncLow_n;
   logic        clkPinIn;
   logic        clkPinOut;
   logic        clkPinOe;
   modport device (input regWrite, regRead, regAddr, regWdata, syncLow_n, clkPinIn,
                   output regRdata, clkPinOut, clkPinOe);
   modport host (output regWrite, regRead, regAddr, regWdata, syncLow_n, clkPinIn,
                 input regRdata, clkPinOut, clkPinOe);
endinterface
`default_nettype wire

// ==== common/acm_pkg.sv ====
// types for the converter mode, clock and result control block
package acm_pkg;
   typedef enum logic [3:0] {
      MODE_CONT      = 4'h0,
      MODE_SINGLE    = 4'h1,
      MODE_STANDBY   = 4'h2,
      MODE_POWERDOWN = 4'h3,
      MODE_IDLE      = 4'h4,
      MODE_INT_ZERO  = 4'h5,
      MODE_INT_FULL  = 4'h6,
      MODE_SYS_ZERO  = 4'h7,
      MODE_SYS_FULL  = 4'h8,
      MODE_DUTY      = 4'h9,
      MODE_SYNC_IDLE = 4'ha,
      MODE_SYNC_LOW_POWER_HOLD = 4'hb
   } acm_mode_type;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_CONV  = 5'h02,
      ST_LOW_POWER_HOLD  = 5'h04,
      ST_CAL   = 5'h08,
      ST_PDOWN = 5'h10
   } acm_state_type;
endpackage

// ==== dv/acm_link_asserts.sv ====
// checks on the link between host and converter ends
`timescale 1ns/1ps
`default_nettype none
module acm_link_asserts
   import acm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        regWrite,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        clkPinOut,
   input  wire logic        clkPinOe,
   input  wire logic        filterReset,
   input  wire logic        mainClockTick,
   input  wire logic        convDone,
   input  var  acm_state_type state
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence ctrlWr;
      regWrite && regAddr == 4'h1;
   endsequence
   mode_legal_a: assert property (ctrlWr |-> regWdata[5:2] <= 4'hb)
      else $error("reserved mode on link");
   idle_hold_a: assert property (state == ST_IDLE |-> filterReset)
      else $error("idle without filter reset");
   conv_run_a: assert property (state == ST_CONV |-> !filterReset)
      else $error("filter reset while converting");
   cal_exit_a: assert property ($fell(state == ST_CAL) |-> state == ST_IDLE)
      else $error("calibration not back to idle");
   pdown_entry_a: assert property ($rose(state == ST_PDOWN) |-> $past(state) == ST_LOW_POWER_HOLD)
      else $error("power-down not from standby");
   tick_pulse_a: assert property (mainClockTick |=> !mainClockTick)
      else $error("main tick longer than a cycle");
   clk_drive_a: assert property (clkPinOe |-> ##[1:660] $changed(clkPinOut))
      else $error("clock pin not toggling");
   oe_select_a: assert property (ctrlWr |-> ##2 clkPinOe == ($past(regWdata[1:0], 2) == 2'b01))
      else $error("clock pin enable wrong");
   reset_state_a: assert property ($rose(reset_n) |-> state == ST_CONV && !clkPinOe)
      else $error("wrong state after reset");
   seq_end_a: assert property (convDone |-> mainClockTick && state == ST_CONV)
      else $error("sequence end off a tick");
   osc_tick_a: assert property (clkPinOe && $past(clkPinOe) && $rose(clkPinOut)
                                |-> $past(mainClockTick))
      else $error("internal tick not on oscillator edge");
endmodule // acm_link_asserts
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for the converter mode, clock and result control pair
`timescale 1ns/1ps
`default_nettype none
module tb
   import acm_pkg::*;
();
   logic          clock, reset_n, psel, penable, pwrite, pready, pslverr, extClockIn, errv;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rdv;
   logic [15:0]   sampleData;
   logic          filterReset, mainClockTick, convDone;
   logic [1:0]    div;
   acm_state_type state;
   int            fail_count, comparisons, n, m;
   acm_link_if    link();
   acm_host u_acm_host (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .extClockIn, .link(link));
   acm_device #(.CAL_LEN(4)) u_acm_device (.clock, .reset_n, .link(link), .sampleData,
      .filterReset, .mainClockTick, .convDone, .state);
   acm_link_asserts u_acm_link_asserts (.clock, .reset_n, .regWrite(link.regWrite),
      .regAddr(link.regAddr), .regWdata(link.regWdata), .clkPinOut(link.clkPinOut),
      .clkPinOe(link.clkPinOe), .filterReset, .mainClockTick, .convDone, .state);
   assign extClockIn = div[1];
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'd1;
      end
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic isWrite, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= isWrite;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n == 0 || pready !== 1'b1; n++) begin
         if (n == 50) begin
            fail_count++;
            $display("ERROR %0t bus timeout got %h exp %h", $time, pready, 1'b1);
            finish_test();
         end
         @(posedge clock);
      end
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      check(errv, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rdv, e);
   endtask
   task automatic wait_state(input acm_state_type s);
      comparisons++;
      for (n = 0; state !== s; n++) begin
         if (n == 2000) begin
            fail_count++;
            $display("ERROR %0t state timeout got %h exp %h", $time, state, s);
            finish_test();
         end
         @(posedge clock);
      end
   endtask
   task automatic sync_pulse;
      wr(12'h008, 32'h0, 1'b0);
      wr(12'h008, 32'h1, 1'b0);
   endtask
   task automatic count_ticks(input int exp);
      int t;
      t = 0;
      repeat (8) @(posedge clock);
      repeat (80) begin
         @(posedge clock);
         t += (mainClockTick === 1'b1);
      end
      check(t, exp);
   endtask
   initial begin
      reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; sampleData = 16'h5a3c; fail_count = 0; comparisons = 0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rd(12'h00c, 32'h0);
      rd(12'h004, 32'h0);
      wr(12'h004, 32'h12, 1'b0);
      wait_state(ST_IDLE);
      check(filterReset, 1'b1);
      for (m = 5; m <= 8; m++) begin
         wr(12'h004, {m[3:0], 2'b10}, 1'b0);
         wait_state(ST_CAL);
         wait_state(ST_IDLE);
         rd(12'h004, 32'h12);
      end
      wr(12'h004, 32'h2a, 1'b0);
      wait_state(ST_IDLE);
      sync_pulse();
      wait_state(ST_CONV);
      wait_state(ST_IDLE);
      rd(12'h00c, 32'h5a3c);
      sampleData <= 16'hc3a5;
      wr(12'h004, 32'h2e, 1'b0);
      wait_state(ST_LOW_POWER_HOLD);
      sync_pulse();
      wait_state(ST_CONV);
      wait_state(ST_LOW_POWER_HOLD);
      rd(12'h00c, 32'hc3a5);
      wr(12'h004, 32'h0e, 1'b0);
      wait_state(ST_PDOWN);
      wr(12'h004, 32'h12, 1'b0);
      wait_state(ST_IDLE);
      wr(12'h004, 32'h0e, 1'b0);
      wait_state(ST_CONV);
      rd(12'h004, 32'h02);
      wr(12'h004, 32'h66, 1'b0);
      wait_state(ST_LOW_POWER_HOLD);
      wait_state(ST_CONV);
      wait_state(ST_LOW_POWER_HOLD);
      wr(12'h004, 32'h32, 1'b1);
      rd(12'h004, 32'h66);
      sampleData <= 16'h1e2d;
      wr(12'h004, 32'h06, 1'b0);
      wait_state(ST_IDLE);
      rd(12'h00c, 32'h1e2d);
      wr(12'h004, 32'h0a, 1'b0);
      wait_state(ST_LOW_POWER_HOLD);
      wr(12'h010, 32'h0, 1'b1);
      wr(12'h004, 32'h12, 1'b0);
      count_ticks(20);
      wr(12'h004, 32'h13, 1'b0);
      count_ticks(10);
      wr(12'h004, 32'h11, 1'b0);
      check(link.clkPinOe, 1'b1);
      repeat (1400) @(posedge clock);
      wr(12'h004, 32'h10, 1'b0);
      check(link.clkPinOe, 1'b0);
      finish_test();
   end
endmodule // tb
`default_nettype wire

// ==== rtl/acm_device.sv ====
// converter end: mode control, main clock select, result register
// How it works
// - idle mode holds filter reset
// - internal calibrations end by returning to idle
// - system calibrations end by returning to idle
// - duty mode alternates conversion and standby
// - sync falling edge converts once, then idle
// - sync falling edge converts once, then standby
// - clock 00 internal oscillator, pin not driven
// - clock 01 internal oscillator, driven on pin
// - clock 10 takes pin clock directly
// - clock 11 halves the pin clock
// - result register holds latest result, resets zero
// - power-down only from standby, else continuous
// - mode field bits 5 to 2, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "acm_cfg.svh"
module acm_device
   import acm_pkg::*;
#(
   parameter int CAL_LEN = 64
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   acm_link_if.device       link,
   input  wire logic [15:0] sampleData,
   output logic             filterReset,
   output logic             mainClockTick,
   output logic             convDone,
   output acm_state_type    state
);
   logic [15:0]   control;
   logic [15:0]   result;
   logic [15:0]   count;
   logic [9:0]    oscCount;
   logic          oscClock;
   logic          pinPrev;
   logic          halfToggle;
   logic          syncPrev;
   acm_state_type next_state;
   logic [15:0]   next_count;
   logic [3:0]    next_mode;
   logic          writeMode;
   logic          doneSeq;

   wire [3:0]  mode       = control[`ACM_MODE_MSB:`ACM_MODE_LSB];
   wire [1:0]  clkSel     = control[`ACM_CLKSEL_MSB:`ACM_CLKSEL_LSB];
   wire        ctlWrite   = link.regWrite && (link.regAddr == `ACM_REG_CONTROL);
   wire [3:0]  wrMode     = link.regWdata[`ACM_MODE_MSB:`ACM_MODE_LSB];
   wire        syncFall   = syncPrev && !link.syncLow_n;
   wire        pinRise    = link.clkPinIn && !pinPrev;
   wire        oscTick    = (oscCount == `ACM_OSC_HALF) && !oscClock;
   wire        intTick    = oscTick;
   wire        extTick    = clkSel[1] && pinRise && (!clkSel[0] || halfToggle);
   wire [15:0] dutyOff    = control[`ACM_DUTY_BIT] ? `ACM_DUTY_OFF_SHORT : `ACM_DUTY_OFF_LONG;
   wire [15:0] calLen     = CAL_LEN[15:0];
   wire [15:0] regRead16  = (link.regAddr == `ACM_REG_CONTROL) ? control :
                            (link.regAddr == `ACM_REG_RESULT)  ? result : 16'h0000;

   assign mainClockTick  = clkSel[1] ? extTick : intTick;
   assign link.clkPinOut = oscClock;
   assign link.clkPinOe  = (clkSel == 2'b01);
   assign link.regRdata  = link.regRead ? regRead16 : 16'h0000;
   assign filterReset    = (state != ST_CONV);
   assign convDone       = doneSeq;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         oscCount   <= 10'h000;
         oscClock   <= 1'b0;
         pinPrev    <= 1'b0;
         halfToggle <= 1'b0;
         syncPrev   <= 1'b1;
      end else begin
         oscCount   <= (oscCount == `ACM_OSC_HALF) ? 10'h000 : oscCount + 10'h001;
         oscClock   <= (oscCount == `ACM_OSC_HALF) ? !oscClock : oscClock;
         pinPrev    <= link.clkPinIn;
         halfToggle <= pinRise ? !halfToggle : halfToggle;
         syncPrev   <= link.syncLow_n;
      end
   end

   // mode/state sequencing, advanced per main clock tick
   always_comb begin
      next_state = state;
      next_count = count;
      next_mode  = mode;
      writeMode  = 1'b0;
      doneSeq    = 1'b0;
      if (ctlWrite) begin
         next_count = 16'h0000;
         unique case (wrMode)
            MODE_CONT, MODE_SINGLE, MODE_DUTY: next_state = ST_CONV;
            MODE_STANDBY:                      next_state = ST_LOW_POWER_HOLD;
            MODE_POWERDOWN: begin
               if (state == ST_LOW_POWER_HOLD || state == ST_PDOWN) begin
                  next_state = ST_PDOWN;
               end else begin
                  next_state = ST_CONV;
                  next_mode  = MODE_CONT;
                  writeMode  = 1'b1;
               end
            end
            MODE_INT_ZERO, MODE_INT_FULL, MODE_SYS_ZERO, MODE_SYS_FULL:
               next_state = ST_CAL;
            MODE_SYNC_LOW_POWER_HOLD: next_state = ST_LOW_POWER_HOLD;
            default:        next_state = ST_IDLE;
         endcase
      end else if (mainClockTick) begin
         next_count = count + 16'h0001;
         unique case (state)
            ST_CAL: begin
               if (count >= calLen) begin
                  next_state = ST_IDLE;
                  next_mode  = MODE_IDLE;
                  writeMode  = 1'b1;
               end
            end
            ST_CONV: begin
               if (count >= `ACM_SEQ_CYCLES) begin
                  doneSeq    = 1'b1;
                  next_count = 16'h0000;
                  unique case (mode)
                     MODE_CONT:      next_state = ST_CONV;
                     MODE_DUTY:      next_state = ST_LOW_POWER_HOLD;
                     MODE_SYNC_LOW_POWER_HOLD: next_state = ST_LOW_POWER_HOLD;
                     MODE_SINGLE, MODE_SYNC_IDLE: next_state = ST_IDLE;
                     default:        next_state = ST_IDLE;
                  endcase
               end
            end
            ST_LOW_POWER_HOLD: begin
               if (mode == MODE_DUTY && count >= dutyOff) begin
                  next_state = ST_CONV;
                  next_count = 16'h0000;
               end
            end
            default: next_count = 16'h0000;
         endcase
      end
      if (!ctlWrite && syncFall && (mode == MODE_SYNC_IDLE || mode == MODE_SYNC_LOW_POWER_HOLD)
          && (state == ST_IDLE || state == ST_LOW_POWER_HOLD)) begin
         next_state = ST_CONV;
         next_count = 16'h0000;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         control <= `ACM_CONTROL_RESET;
         state   <= ST_CONV;
         count   <= 16'h0000;
      end else begin
         if (ctlWrite) begin
            control <= link.regWdata;
         end
         if (writeMode) begin
            control[`ACM_MODE_MSB:`ACM_MODE_LSB] <= next_mode;
         end
         state <= next_state;
         count <= next_count;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         result <= `ACM_RESULT_RESET;
      end else if (doneSeq) begin
         result <= sampleData;
      end
   end
endmodule // acm_device
`default_nettype wire

// ==== rtl/acm_host.sv ====
// host end: APB slave with order registers, drives the converter link
`timescale 1ns/1ps
`default_nettype none
`include "acm_cfg.svh"
module acm_host
   import acm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extClockIn,
   acm_link_if.host         link
);
   logic        syncHold_n;

   wire access   = psel && penable;
   wire ctlAddr  = (paddr == `ACM_APB_CONTROL);
   wire wrCtl    = access && pwrite && ctlAddr;
   wire wrSync   = access && pwrite && (paddr == `ACM_APB_STATUS);
   wire rdLink   = access && !pwrite && (ctlAddr || (paddr == `ACM_APB_RESULT));
   wire mapped   = (paddr == `ACM_APB_CONTROL) || (paddr == `ACM_APB_STATUS)
                   || (paddr == `ACM_APB_RESULT);

   // mode codes above 1011 are refused at the host
   wire badMode  = wrCtl && (pwdata[`ACM_MODE_MSB:`ACM_MODE_LSB] > 4'hb);

   assign pready        = 1'b1;
   assign pslverr       = access && (!mapped || badMode);
   assign link.regWrite = wrCtl && !badMode;
   assign link.regRead  = rdLink;
   assign link.regAddr  = ctlAddr ? `ACM_REG_CONTROL : `ACM_REG_RESULT;
   assign link.regWdata = pwdata[15:0];
   assign link.syncLow_n = syncHold_n;
   assign link.clkPinIn = extClockIn;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         syncHold_n <= 1'b1;
      end else begin
         if (wrSync) begin
            syncHold_n <= pwdata[0];
         end
      end
   end

   always_comb begin
      unique case (paddr)
         `ACM_APB_CONTROL: prdata = {16'h0000, link.regRdata};
         `ACM_APB_STATUS:  prdata = {29'h0, link.clkPinOe, link.clkPinOut, syncHold_n};
         `ACM_APB_RESULT:  prdata = {16'h0000, link.regRdata};
         default:          prdata = 32'h0000_0000;
      endcase
   end
endmodule // acm_host
`default_nettype wire
